//--- verilog/msq_pkg.sv
// Shared constants for the motion set sequencer: word bit positions, set table
// layout, motion function codes, status bit patterns and error reactions.
// Assumes one drive clock; imported whole by every design module.
package msq_pkg;
   localparam int CW_START_BIT = 4;
   localparam int CW_CHANGE_BIT = 5;
   localparam int CW_ACK_BIT = 7;
   localparam int SW1_TARGET_BIT = 9;
   localparam int SW1_MARK_BIT = 15;
   localparam int SW2_PSB_LO = 12;
   localparam int PSB_N = 3;
   localparam int SET_AW = 5;
   localparam int SET_COUNT = 31;
   localparam logic [SET_AW-1:0] SET_HOMING = 5'h00;
   localparam int FUNC_W = 3;
   localparam logic [2:0] F_EMPTY = 3'h0;
   localparam logic [2:0] F_ABS = 3'h1;
   localparam logic [2:0] F_REL = 3'h2;
   localparam logic [2:0] F_GEAR = 3'h3;
   localparam logic [2:0] F_SEARCH = 3'h4;
   localparam logic [2:0] F_OFFSET = 3'h5;
   localparam logic [2:0] F_VELO = 3'h6;
   localparam logic [2:0] F_STOP = 3'h7;
   localparam logic [1:0] PSB_KEEP = 2'h0;
   localparam logic [1:0] PSB_ZERO = 2'h1;
   localparam logic [1:0] PSB_ONE = 2'h2;
   localparam logic [1:0] ERR_NONE = 2'h0;
   localparam logic [1:0] ERR_RAMP_STOP = 2'h1;
   localparam logic [1:0] ERR_RAMP_OFF = 2'h2;
   typedef enum logic [5:0] {
      ST_IDLE = 6'h01,
      ST_HOME = 6'h02,
      ST_MOVE = 6'h04,
      ST_GEAR = 6'h08,
      ST_VELO = 6'h10,
      ST_STOP = 6'h20
   } msq_state_e;
endpackage

//--- verilog/msq_set_table.sv
// Set table: homing entry plus stored motion sets, written by configuration.
// Assumes writes come from the configuration side; reads are combinational.
`timescale 1ns/1ps
module msq_set_table import msq_pkg::*; #(
   parameter int DEPTH = SET_COUNT + 1,
   parameter int POS_W = 32,
   parameter int VAL_W = 32
) (
   // Clock and reset
   input wire logic sys_clk,
   input wire logic rst_b,
   // Write port
   input wire logic we,
   input wire logic [SET_AW-1:0] waddr,
   input wire logic [FUNC_W-1:0] wfunc,
   input wire logic [POS_W-1:0] wtarget,
   input wire logic [VAL_W-1:0] wvel,
   input wire logic [VAL_W-1:0] wacc,
   input wire logic [VAL_W-1:0] wdec,
   input wire logic [VAL_W-1:0] wjerk,
   input wire logic [2*PSB_N-1:0] wpsb,
   // Read port
   input wire logic [SET_AW-1:0] raddr,
   output logic [FUNC_W-1:0] rfunc,
   output logic [POS_W-1:0] rtarget,
   output logic [VAL_W-1:0] rvel,
   output logic [VAL_W-1:0] racc,
   output logic [VAL_W-1:0] rdec,
   output logic [VAL_W-1:0] rjerk,
   output logic [2*PSB_N-1:0] rpsb
);
   localparam int DW = POS_W + 4 * VAL_W + 2 * PSB_N;
   logic [FUNC_W-1:0] func_mem [DEPTH];
   logic [DW-1:0] data_mem [DEPTH];

   // Only the function code is reset, so an unloaded entry reads as empty.
   for (genvar g = 0; g < DEPTH; g++) begin : g_func
      always_ff @(posedge sys_clk or negedge rst_b) begin
         if (!rst_b) begin
            func_mem[g] <= F_EMPTY;
         end else if (we && waddr == SET_AW'(g)) begin
            func_mem[g] <= wfunc;
         end
      end
   end

   always_ff @(posedge sys_clk) begin
      if (we) begin
         data_mem[waddr] <= {wtarget, wvel, wacc, wdec, wjerk, wpsb};
      end
   end

   assign rfunc = func_mem[raddr];
   assign {rtarget, rvel, racc, rdec, rjerk, rpsb} = data_mem[raddr];
endmodule

//--- verilog/msq_gear.sv
// Electronic gear: scales master position steps by numerator over denominator.
// Assumes one master step per clock; the remainder is carried so no drift builds.
`timescale 1ns/1ps
module msq_gear import msq_pkg::*; #(
   parameter int GW = 16
) (
   // Clock and reset
   input wire logic sys_clk,
   input wire logic rst_b,
   // Gear control
   input wire logic en,
   input wire logic [GW-1:0] master_delta,
   input wire logic [GW-1:0] num,
   input wire logic [GW-1:0] den,
   // Slave step
   output logic [2*GW:0] step
);
   localparam int PW = 2 * GW + 1;
   logic signed [PW-1:0] rem;
   logic signed [PW-1:0] prod;
   logic signed [PW-1:0] quo;
   logic signed [PW-1:0] den_x;

   // A negative numerator or denominator reverses the slave direction.
   always_comb begin
      den_x = PW'($signed(den));
      prod = PW'($signed(master_delta)) * PW'($signed(num)) + rem;
      quo = (den_x == '0) ? '0 : prod / den_x;
   end

   always_ff @(posedge sys_clk or negedge rst_b) begin
      if (!rst_b) begin
         rem <= '0;
         step <= '0;
      end else if (en) begin
         rem <= prod - quo * den_x;
         step <= quo;
      end else begin
         rem <= '0;
         step <= '0;
      end
   end
endmodule

//--- verilog/msq_sequencer.sv
// Motion set sequencer: selects, starts and changes over motion sets and
// drives the status word flags. Assumes a profile generator downstream that
// drops its reached inputs within one cycle of cmd_load.
`timescale 1ns/1ps
module msq_sequencer import msq_pkg::*; #(
   parameter int POS_W = 32,
   parameter int VAL_W = 32,
   parameter int GW = 16,
   parameter int ERR_N = 8,
   parameter int EW = 3
) (
   // Clock and reset
   input wire logic sys_clk,
   input wire logic rst_b,
   // Fieldbus words
   input wire logic [15:0] cw1,
   input wire logic [SET_AW-1:0] set_sel,
   input wire logic sel_mode,
   output logic [15:0] sw1,
   output logic [15:0] sw2,
   output logic reached_output,
   // Set table load
   input wire logic tbl_we,
   input wire logic [SET_AW-1:0] tbl_waddr,
   input wire logic [FUNC_W-1:0] tbl_wfunc,
   input wire logic [POS_W-1:0] tbl_wtarget,
   input wire logic [VAL_W-1:0] tbl_wvel,
   input wire logic [VAL_W-1:0] tbl_wacc,
   input wire logic [VAL_W-1:0] tbl_wdec,
   input wire logic [VAL_W-1:0] tbl_wjerk,
   input wire logic [2*PSB_N-1:0] tbl_wpsb,
   // Axis feedback
   input wire logic [POS_W-1:0] act_pos,
   input wire logic in_pos,
   input wire logic speed_ok,
   input wire logic gear_sync,
   input wire logic standstill,
   input wire logic homing_done,
   input wire logic [GW-1:0] master_delta,
   // Registration mark
   input wire logic mark_pulse,
   input wire logic [POS_W-1:0] mark_pos,
   input wire logic [POS_W-1:0] ignore_zone_begin,
   input wire logic [POS_W-1:0] ignore_zone_end,
   // Error reaction
   input wire logic err_cfg_we,
   input wire logic [EW-1:0] err_cfg_idx,
   input wire logic [1:0] err_cfg_val,
   input wire logic err_valid,
   input wire logic [EW-1:0] err_idx,
   output logic [1:0] err_reaction,
   output logic power_off,
   // Profile command
   output logic cmd_load,
   output logic [FUNC_W-1:0] cmd_func,
   output logic [POS_W-1:0] cmd_target,
   output logic [VAL_W-1:0] cmd_vel,
   output logic [VAL_W-1:0] cmd_acc,
   output logic [VAL_W-1:0] cmd_dec,
   output logic [VAL_W-1:0] cmd_jerk,
   output logic homing_start,
   output logic [2*GW:0] gear_step
);
   msq_state_e state;
   logic [FUNC_W-1:0] cur_func;
   logic [SET_AW-1:0] cur_set;
   logic [2*PSB_N-1:0] cur_psb;
   logic sel_q;
   logic start_d;
   logic [GW-1:0] gear_num;
   logic [GW-1:0] gear_den;
   logic [1:0] err_cfg [ERR_N];
   logic [SET_AW-1:0] rd_addr;
   logic [FUNC_W-1:0] rd_func;
   logic [POS_W-1:0] rd_target;
   logic [VAL_W-1:0] rd_vel;
   logic [VAL_W-1:0] rd_acc;
   logic [VAL_W-1:0] rd_dec;
   logic [VAL_W-1:0] rd_jerk;
   logic [2*PSB_N-1:0] rd_psb;
   logic start_rise;
   logic busy;
   logic sel_nz;
   logic settle;
   logic mark_in_zone;
   logic take_err;
   logic take_mark;
   logic go;
   logic take_home;
   logic take_stop;
   logic take_chg;
   logic take_new;
   logic accept;
   logic next_b9;
   logic next_mark;
   logic psb_go;
   logic [PSB_N-1:0] next_psb;
   logic [POS_W-1:0] next_tgt;

   // Permitted dynamic changeovers by running and destination function.
   function automatic logic chg_ok(input logic [FUNC_W-1:0] from, input logic [FUNC_W-1:0] to);
      if (from == F_STOP || from == F_EMPTY) begin
         return 1'b0;
      end
      if (from == F_GEAR) begin
         return to inside {F_ABS, F_REL, F_SEARCH, F_GEAR};
      end
      return to inside {F_ABS, F_REL, F_VELO, F_SEARCH, F_GEAR};
   endfunction

   function automatic msq_state_e st_of(input logic [FUNC_W-1:0] f);
      if (f == F_GEAR) begin
         return ST_GEAR;
      end
      if (f == F_VELO) begin
         return ST_VELO;
      end
      if (f == F_STOP) begin
         return ST_STOP;
      end
      return ST_MOVE;
   endfunction

   function automatic logic [PSB_N-1:0] psb_mix(input logic [PSB_N-1:0] old,
                                                input logic [2*PSB_N-1:0] cfg);
      logic [PSB_N-1:0] res;
      res = old;
      for (int i = 0; i < PSB_N; i++) begin
         if (cfg[2*i +: 2] == PSB_ZERO) begin
            res[i] = 1'b0;
         end else if (cfg[2*i +: 2] == PSB_ONE) begin
            res[i] = 1'b1;
         end
      end
      return res;
   endfunction

   // Entry 0 is the homing run; entries 1 to 31 are stored sets.
   msq_set_table #(.DEPTH(SET_COUNT + 1), .POS_W(POS_W), .VAL_W(VAL_W)) u_table (
      .sys_clk(sys_clk),
      .rst_b(rst_b),
      .we(tbl_we),
      .waddr(tbl_waddr),
      .wfunc(tbl_wfunc),
      .wtarget(tbl_wtarget),
      .wvel(tbl_wvel),
      .wacc(tbl_wacc),
      .wdec(tbl_wdec),
      .wjerk(tbl_wjerk),
      .wpsb(tbl_wpsb),
      .raddr(rd_addr),
      .rfunc(rd_func),
      .rtarget(rd_target),
      .rvel(rd_vel),
      .racc(rd_acc),
      .rdec(rd_dec),
      .rjerk(rd_jerk),
      .rpsb(rd_psb)
   );

   msq_gear #(.GW(GW)) u_gear (
      .sys_clk(sys_clk),
      .rst_b(rst_b),
      .en(state == ST_GEAR),
      .master_delta(master_delta),
      .num(gear_num),
      .den(gear_den),
      .step(gear_step)
   );

   // Decode of one event per cycle; an error beats a mark, a mark beats a start.
   always_comb begin
      start_rise = cw1[CW_START_BIT] & ~start_d;
      busy = (state != ST_IDLE);
      sel_nz = (set_sel != SET_HOMING);
      settle = ~cmd_load;
      mark_in_zone = ($signed(mark_pos) >= $signed(ignore_zone_begin)) &&
                     ($signed(mark_pos) <= $signed(ignore_zone_end));
      take_err = err_valid && err_cfg[err_idx] != ERR_NONE && busy && state != ST_STOP;
      take_mark = ~take_err && state == ST_MOVE && cur_func == F_SEARCH && mark_pulse &&
                  ~mark_in_zone && ~(in_pos & settle);
      rd_addr = take_mark ? cur_set + SET_AW'(1) : set_sel;
      go = start_rise & ~take_err & ~take_mark;
      take_home = go && ~busy && ~sel_nz;
      take_stop = go && sel_nz && rd_func == F_STOP && state != ST_HOME &&
                  state != ST_STOP;
      take_chg = go && busy && cw1[CW_CHANGE_BIT] && sel_nz &&
                 chg_ok(cur_func, rd_func);
      take_new = go && sel_nz && ~take_chg && (~busy || state == ST_VELO) &&
                 (rd_func inside {F_ABS, F_REL, F_SEARCH, F_GEAR, F_VELO});
      accept = take_err | take_mark | take_home | take_stop | take_chg | take_new;
   end

   always_comb begin
      if (take_mark) begin
         next_tgt = mark_pos + rd_target;
      end else if (rd_func inside {F_REL, F_SEARCH}) begin
         next_tgt = act_pos + rd_target;
      end else begin
         next_tgt = rd_target;
      end
   end

   // Bit 9 means target, gear, speed or standstill reached, or homing done, depending on the running set.
   always_comb begin
      next_b9 = sw1[SW1_TARGET_BIT];
      if (accept) begin
         next_b9 = 1'b0;
      end else begin
         unique case (state)
            ST_IDLE: next_b9 = sw1[SW1_TARGET_BIT];
            ST_HOME: next_b9 = homing_done;
            ST_MOVE: next_b9 = in_pos & settle;
            ST_GEAR: next_b9 = gear_sync & settle;
            ST_VELO: next_b9 = speed_ok & settle;
            ST_STOP: next_b9 = standstill & settle;
         endcase
      end
      next_mark = take_mark | (sw1[SW1_MARK_BIT] & ~accept);
      psb_go = (take_mark & sel_q) |
               (next_b9 & ~sw1[SW1_TARGET_BIT] & ~accept & state != ST_HOME &
                (state != ST_MOVE || sel_q || !(cur_func inside {F_SEARCH, F_OFFSET})));
      next_psb = psb_go ? psb_mix(sw2[SW2_PSB_LO +: PSB_N], cur_psb) :
                 sw2[SW2_PSB_LO +: PSB_N];
   end

   always_ff @(posedge sys_clk or negedge rst_b) begin
      if (!rst_b) begin
         start_d <= 1'b0;
      end else begin
         start_d <= cw1[CW_START_BIT];
      end
   end

   // Sequencing state and the captured set number.
   always_ff @(posedge sys_clk or negedge rst_b) begin
      if (!rst_b) begin
         state <= ST_IDLE;
         cur_func <= F_EMPTY;
         cur_set <= SET_HOMING;
         cur_psb <= '0;
         sel_q <= 1'b0;
      end else if (take_err) begin
         state <= ST_STOP;
         cur_func <= F_STOP;
         cur_psb <= '0;
      end else if (take_mark) begin
         cur_func <= F_OFFSET;
         cur_set <= rd_addr;
         cur_psb <= rd_psb;
      end else if (take_home) begin
         state <= ST_HOME;
         cur_func <= F_EMPTY;
         cur_set <= SET_HOMING;
         cur_psb <= '0;
      end else if (take_stop || take_chg || take_new) begin
         state <= st_of(rd_func);
         cur_func <= rd_func;
         cur_set <= set_sel;
         cur_psb <= rd_psb;
         if (!take_chg) begin
            sel_q <= sel_mode;
         end
      end else if ((state == ST_MOVE && in_pos && settle) ||
                   (state == ST_STOP && standstill && settle) ||
                   (state == ST_HOME && homing_done)) begin
         state <= ST_IDLE;
      end
   end

   // Profile command towards the trajectory generator.
   always_ff @(posedge sys_clk or negedge rst_b) begin
      if (!rst_b) begin
         cmd_load <= 1'b0;
         homing_start <= 1'b0;
         cmd_func <= F_EMPTY;
         cmd_target <= '0;
         cmd_vel <= '0;
         cmd_acc <= '0;
         cmd_dec <= '0;
         cmd_jerk <= '0;
         gear_num <= '0;
         gear_den <= '0;
      end else begin
         cmd_load <= take_err | take_mark | take_stop | take_chg | take_new;
         homing_start <= take_home;
         if (take_err) begin
            cmd_func <= F_STOP;
         end else if (take_stop) begin
            cmd_func <= F_STOP;
            cmd_dec <= rd_dec;
            cmd_jerk <= rd_jerk;
         end else if (take_mark || take_chg || take_new) begin
            cmd_func <= take_mark ? F_OFFSET : rd_func;
            cmd_target <= next_tgt;
            cmd_vel <= rd_vel;
            if (rd_func == F_GEAR) begin
               gear_num <= rd_target[GW-1:0];
               gear_den <= rd_vel[GW-1:0];
            end
            if (take_chg) begin
               if (rd_func == F_GEAR) begin
                  cmd_dec <= cmd_acc;
               end
            end else begin
               cmd_acc <= rd_acc;
               cmd_dec <= (rd_func == F_GEAR) ? rd_acc : rd_dec;
            end
            if (rd_func == F_GEAR || rd_func == F_VELO) begin
               cmd_jerk <= '0;
            end else if (!take_chg) begin
               cmd_jerk <= rd_jerk;
            end
         end
      end
   end

   // Status words; unused bits stay zero.
   always_ff @(posedge sys_clk or negedge rst_b) begin
      if (!rst_b) begin
         sw1 <= '0;
         sw2 <= '0;
         reached_output <= 1'b0;
      end else begin
         sw1[SW1_TARGET_BIT] <= next_b9;
         sw1[SW1_MARK_BIT] <= next_mark;
         reached_output <= next_b9;
         sw2[SW2_PSB_LO +: PSB_N] <= next_psb;
      end
   end

   // Error reaction table; each entry resets to ramp and de-energize.
   for (genvar e = 0; e < ERR_N; e++) begin : g_err
      always_ff @(posedge sys_clk or negedge rst_b) begin
         if (!rst_b) begin
            err_cfg[e] <= ERR_RAMP_OFF;
         end else if (err_cfg_we && err_cfg_idx == EW'(e)) begin
            err_cfg[e] <= err_cfg_val;
         end
      end
   end

   // De-energize holds until acknowledged; a new de-energize error in the same cycle wins.
   always_ff @(posedge sys_clk or negedge rst_b) begin
      if (!rst_b) begin
         err_reaction <= ERR_NONE;
         power_off <= 1'b0;
      end else begin
         if (err_valid) begin
            err_reaction <= err_cfg[err_idx];
         end
         if (err_valid && err_cfg[err_idx] == ERR_RAMP_OFF) begin
            power_off <= 1'b1;
         end else if (cw1[CW_ACK_BIT]) begin
            power_off <= 1'b0;
         end
      end
   end

   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (!rst_b);

   property p_home;
      take_home |=> state == ST_HOME && homing_start;
   endproperty
   a_home: assert property (p_home) else $error("homing run not launched");
   property p_search;
      start_rise && !busy && sel_nz && rd_func == F_SEARCH |=>
         state == ST_MOVE && cur_func == F_SEARCH && cur_set == $past(set_sel);
   endproperty
   a_search: assert property (p_search) else $error("search set not started");
   property p_mark;
      take_mark |=> sw1[SW1_MARK_BIT] && cmd_load && cmd_func == F_OFFSET;
   endproperty
   a_mark: assert property (p_mark) else $error("mark not reported");
   property p_offset;
      take_mark |=> cmd_target == $past(mark_pos) + $past(rd_target);
   endproperty
   a_offset: assert property (p_offset) else $error("offset not from mark");
   property p_ignore;
      state == ST_MOVE && cur_func == F_SEARCH && mark_pulse && mark_in_zone && !err_valid &&
         !start_rise |=> cur_func == F_SEARCH && !sw1[SW1_MARK_BIT];
   endproperty
   a_ignore: assert property (p_ignore) else $error("mark in zone taken");
   property p_reached;
      reached_output == sw1[SW1_TARGET_BIT];
   endproperty
   a_reached: assert property (p_reached) else $error("reached output differs");
   property p_gear_drop;
      state == ST_GEAR && !gear_sync && !start_rise && !err_valid |=> !sw1[SW1_TARGET_BIT];
   endproperty
   a_gear_drop: assert property (p_gear_drop) else $error("gear reached held");
   property p_nojerk;
      state == ST_GEAR || state == ST_VELO |-> cmd_jerk == '0;
   endproperty
   a_nojerk: assert property (p_nojerk) else $error("jerk limit in gear");
   property p_home_stop;
      state == ST_HOME && start_rise && !homing_done && !err_valid |=> state == ST_HOME;
   endproperty
   a_home_stop: assert property (p_home_stop) else $error("homing interrupted");
   property p_no_chg;
      start_rise && busy && !cw1[CW_CHANGE_BIT] && state != ST_VELO && rd_func != F_STOP &&
         !take_err && !take_mark |=> cur_set == $past(cur_set);
   endproperty
   a_no_chg: assert property (p_no_chg) else $error("changeover without bit 5");
   property p_velo;
      state == ST_VELO && !start_rise && !err_valid [*2] |=> state == ST_VELO;
   endproperty
   a_velo: assert property (p_velo) else $error("velocity set ended");

   c_home: cover property (take_home ##[1:1000] state == ST_IDLE);
   c_mark: cover property (take_mark ##[1:1000] sw1[SW1_TARGET_BIT]);
   c_chg: cover property (take_chg);
   c_stop: cover property (state == ST_STOP ##1 state == ST_IDLE);
endmodule

//--- dv/msq_axis_model.sv
// Axis feedback model: answers each profile command after DLY cycles.
// Assumes the drive pulses cmd_load or homing_start for one cycle.
`timescale 1ns/1ps
module msq_axis_model import msq_pkg::*; #(parameter int DLY = 20) (
   // Drive side
   input wire logic sys_clk,
   input wire logic rst_b,
   input wire logic cmd_load,
   input wire logic [FUNC_W-1:0] cmd_func,
   input wire logic homing_start,
   // Feedback levels
   output logic in_pos,
   output logic speed_ok,
   output logic gear_sync,
   output logic standstill,
   output logic homing_done
);
   int cnt;
   logic [FUNC_W-1:0] fn;
   logic done;
   // Levels fall inside the load cycle, the only cycle the drive ignores them.
   assign done = rst_b & !cmd_load & !homing_start & (cnt == 0);
   assign in_pos = done & (fn inside {F_ABS, F_REL, F_SEARCH, F_OFFSET});
   assign speed_ok = done & (fn == F_VELO);
   assign gear_sync = done & (fn == F_GEAR);
   assign standstill = done & (fn == F_STOP);
   assign homing_done = done & (fn == F_EMPTY);
   always_ff @(posedge sys_clk or negedge rst_b) begin
      if (!rst_b) begin
         cnt <= 0;
         fn <= F_EMPTY;
      end else if (cmd_load | homing_start) begin
         cnt <= DLY;
         fn <= homing_start ? F_EMPTY : cmd_func;
      end else if (cnt > 0) begin
         cnt <= cnt - 1;
      end
   end
endmodule

//--- dv/msq_sequencer_tb.sv
// Bench for the motion set sequencer beside an axis feedback model.
// Assumes a 10 MHz clock; each command load is matched to a queued note.
`timescale 1ns/1ps
module msq_sequencer_tb import msq_pkg::*;;
   logic sys_clk = 0, rst_b = 0, tbl_we = 0, mark_pulse = 0, err_valid = 0, err_cfg_we = 0;
   logic [15:0] cw1 = '0, master_delta = '0, sw1, sw2;
   logic [4:0] set_sel = '0, tbl_waddr = '0;
   logic [2:0] tbl_wfunc = '0, err_cfg_idx = '0, err_idx = '0, cmd_func;
   logic [31:0] tbl_wtarget = '0, tbl_wvel = '0, mark_pos = '0, cmd_target, t, mp;
   logic [31:0] cmd_vel, cmd_acc, cmd_dec, cmd_jerk;
   logic [5:0] tbl_wpsb = '0;
   logic [1:0] err_cfg_val = '0, err_reaction;
   logic in_pos, speed_ok, gear_sync, standstill, homing_done, reached_output, power_off;
   logic cmd_load, homing_start, sel_mode = 1;
   logic [32:0] gear_step;
   logic [34:0] expq[$];
   int seed, n_home = 0, mismatches = 0, n_compared = 0;
   // Deceleration is the inverse of the velocity field so kept and adopted values differ.
   msq_sequencer DUT (
      .sys_clk, .rst_b, .cw1, .set_sel, .sel_mode, .sw1, .sw2, .reached_output,
      .tbl_we, .tbl_waddr, .tbl_wfunc, .tbl_wtarget, .tbl_wvel, .tbl_wacc(tbl_wvel),
      .tbl_wdec(~tbl_wvel), .tbl_wjerk(tbl_wtarget), .tbl_wpsb, .act_pos(t),
      .in_pos, .speed_ok, .gear_sync, .standstill, .homing_done, .master_delta,
      .mark_pulse, .mark_pos, .ignore_zone_begin(32'h1000), .ignore_zone_end(32'h2000),
      .err_cfg_we, .err_cfg_idx, .err_cfg_val, .err_valid, .err_idx, .err_reaction,
      .power_off, .cmd_load, .cmd_func, .cmd_target, .cmd_vel, .cmd_acc, .cmd_dec,
      .cmd_jerk, .homing_start, .gear_step);
   msq_axis_model u_axis (.sys_clk, .rst_b, .cmd_load, .cmd_func, .homing_start,
      .in_pos, .speed_ok, .gear_sync, .standstill, .homing_done);
   initial forever #50 sys_clk = ~sys_clk;
   task automatic tick();
      @(posedge sys_clk);
      #2;
   endtask
   task automatic chk(input string nm, input logic [35:0] e, input logic [35:0] s);
      n_compared++;
      if (s !== e) begin
         mismatches++;
         $display("MISMATCH %s expected %h seen %h", nm, e, s);
      end
   endtask
   task automatic finish_test();
      if (mismatches == 0 && n_compared > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask
   task automatic wr(input logic [4:0] a, input logic [2:0] f, input logic [31:0] v,
                     input logic [31:0] s, input logic [5:0] p);
      tick();
      {tbl_we, tbl_waddr, tbl_wfunc, tbl_wtarget, tbl_wvel, tbl_wpsb} = {1'b1, a, f, v, s, p};
      tick();
      tbl_we = 1'b0;
   endtask
   // A note whose function is empty means no load may follow.
   task automatic start(input logic [4:0] s, input logic c, input logic [34:0] e);
      tick();
      {cw1, set_sel} = {10'h000, c, 1'b1, 4'h0, s};
      if (e[34:32] != F_EMPTY) expq.push_back(e);
      tick();
      cw1[4] = 1'b0;
      tick();
   endtask
   task automatic mark(input logic [31:0] p);
      repeat (3) tick();
      {mark_pulse, mark_pos} = {1'b1, p};
      tick();
      {mark_pulse, mark_pos} = {1'b0, ~p};
      tick();
   endtask
   task automatic err(input logic w, input logic [2:0] i);
      tick();
      {err_cfg_we, err_valid, err_cfg_idx, err_idx, err_cfg_val} = {w, !w, i, i, 2'h0};
      tick();
      {err_cfg_we, err_valid} = 2'h0;
      tick();
   endtask
   task automatic await();
      for (int k = 0; k < 200 && sw1[9] !== 1'b1; k++) tick();
      chk("sw1_9", 1, sw1[9]);
   endtask
   always @(posedge sys_clk) begin
      #1;
      // The homing pulse stands one cycle only, so it is counted here.
      if (homing_start === 1'b1) n_home++;
      if (cmd_load === 1'b1) begin
         if (expq.size() == 0) chk("cmd_load", 0, 1);
         else chk("cmd", expq.pop_front(), {cmd_func, cmd_target});
      end
   end
   initial begin
      #500000;
      mismatches++;
      finish_test();
   end
   initial begin
      seed = 52908;
      t = 32'($random(seed)) & 32'h7FFF;
      mp = 32'($random(seed)) & 32'h0FFF;
      master_delta = 16'(($random(seed) & 7) + 1);
      repeat (12) @(posedge sys_clk);
      #2;
      rst_b = 1'b1;
      wr(1, F_ABS, t, 32'h10, 6'h02);
      wr(2, F_SEARCH, 32'h500, 32'h10, 6'h00);
      wr(3, F_OFFSET, 32'h40, 32'h10, 6'h08);
      wr(4, F_VELO, 32'h0, 32'h20, 6'h00);
      wr(5, F_STOP, 32'h7, 32'h30, 6'h20);
      wr(6, F_GEAR, 32'h2, 32'h1, 6'h01);
      wr(7, F_GEAR, 32'hFFFF, 32'h1, 6'h00);
      start(1, 0, {F_ABS, t});
      await();
      chk("reached_output", 1, reached_output);
      chk("sw2_12", 1, sw2[12]);
      start(2, 0, {F_SEARCH, t + 32'h500});
      expq.push_back({F_OFFSET, mp + 32'h40});
      mark(mp);
      chk("sw1_15", 1, sw1[15]);
      await();
      chk("sw2_13", 1, sw2[13]);
      start(2, 0, {F_SEARCH, t + 32'h500});
      mark(32'h1800);
      chk("sw1_15", 0, sw1[15]);
      await();
      mark(32'h0100);
      chk("sw1_15", 0, sw1[15]);
      // The offset set now clears bit 13, which must not show without set selection.
      wr(3, F_OFFSET, 32'h40, 32'h10, 6'h04);
      sel_mode = 1'b0;
      start(2, 0, {F_SEARCH, t + 32'h500});
      expq.push_back({F_OFFSET, mp + 32'h40});
      mark(mp);
      await();
      chk("sw2_13", 1, sw2[13]);
      sel_mode = 1'b1;
      start(6, 0, {F_GEAR, 32'h2});
      await();
      chk("sw2_12", 0, sw2[12]);
      chk("cmd_dec", 32'h1, cmd_dec);
      chk("cmd_jerk", 0, cmd_jerk);
      chk("gear_step", 36'(2 * master_delta), gear_step);
      start(1, 0, 35'h0);
      start(4, 1, 35'h0);
      start(7, 1, {F_GEAR, 32'hFFFF});
      chk("sw1_9", 0, sw1[9]);
      await();
      chk("gear_step", {3'h0, 33'h0 - 33'(master_delta)}, gear_step);
      start(1, 1, {F_ABS, t});
      await();
      chk("cmd_vel", 32'h10, cmd_vel);
      chk("cmd_acc", 32'h1, cmd_acc);
      chk("cmd_jerk", 0, cmd_jerk);
      start(4, 0, {F_VELO, 32'h0});
      await();
      start(5, 0, {F_STOP, 32'h0});
      await();
      chk("sw2_14", 1, sw2[14]);
      chk("cmd_dec", 32'hFFFFFFCF, cmd_dec);
      chk("cmd_jerk", 32'h7, cmd_jerk);
      start(0, 0, 35'h0);
      chk("homing_start", 1, n_home);
      start(5, 0, 35'h0);
      repeat (30) tick();
      chk("homing_start", 1, n_home);
      err(0, 0);
      chk("err_reaction", 2, err_reaction);
      chk("power_off", 1, power_off);
      err(1, 1);
      err(0, 1);
      chk("err_reaction", 0, err_reaction);
      cw1[7] = 1'b1;
      tick();
      chk("power_off", 0, power_off);
      chk("queue", 0, expq.size());
      finish_test();
   end
endmodule
